// >>> data_address_generation_stack_check.sv
`timescale 1ns/1ps

module data_address_generation_stack_check (
  input wire logic clock,
  input wire logic rst,
  input wire agu_pkg::agu_req_s req,
  input wire logic [15:0] op1_val,
  input wire logic [3:0] op1_idx,
  input wire agu_pkg::stack_op_e stack_op,
  input wire logic [15:0] stack_ptr_val,
  input wire logic [22:0] pc_val,
  input wire logic [7:0] status_low_byte,
  input wire logic limit_wr,
  input wire logic [15:0] limit_wdata,
  input wire logic boot_secure_en,
  input wire logic [15:0] boot_secure_lo,
  input wire logic [15:0] boot_secure_hi,
  input wire logic segment_secure_en,
  input wire logic [15:0] segment_secure_lo,
  input wire logic [15:0] segment_secure_hi,
  input wire logic exec_in_boot_flash,
  input wire logic exec_in_secure_flash,
  output agu_pkg::agu_rsp_s rsp,
  output logic [15:0] op1_out,
  output logic stk_valid,
  output logic [15:0] stk_addr,
  output logic stk_write,
  output logic [15:0] stk_wdata_lo,
  output logic [15:0] stk_wdata_hi,
  output logic [15:0] next_sp_out,
  output logic stack_error,
  output logic access_refused,
  output logic [15:0] stack_limit_reg
);

  // ********************************************************************
  // helpers
  // ********************************************************************
  // signed pointer modification, used for pre and post modes and the stack
  function automatic logic [15:0] ptr_add(input logic [15:0] base, input logic [15:0] delta);
    ptr_add = base + delta;
  endfunction

  // inclusive window test for the secure segments
  function automatic logic in_window(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_window = (a >= lo) && (a <= hi);
  endfunction

  // ********************************************************************
  // stack limit, deliberately without reset so it stays unknown
  // ********************************************************************
  logic [15:0] limit_q;

  // no reset branch: contents are unknown until software writes
  // a stack access in the same cycle as a write still compares against the old limit
  always_ff @(posedge clock) begin
    if (limit_wr) begin
      limit_q <= limit_wdata & agu_pkg::ALIGN_MASK;
    end
  end

  // ********************************************************************
  // effective address for the decoded operand
  // ********************************************************************
  // one-hot mode decode; an illegal code selects no path and forms address zero
  wire is_file = req.mode == agu_pkg::MODE_FILE_DIRECT;
  wire is_file_full = req.mode == agu_pkg::MODE_FILE_FULL;
  wire is_indirect = req.mode == agu_pkg::MODE_INDIRECT;
  wire is_post = req.mode == agu_pkg::MODE_POST_MOD;
  wire is_pre = req.mode == agu_pkg::MODE_PRE_MOD;
  wire is_roff = req.mode == agu_pkg::MODE_REG_OFFSET;
  wire is_loff = req.mode == agu_pkg::MODE_LIT_OFFSET;
  wire is_lit5 = req.mode == agu_pkg::MODE_LIT5;
  wire is_lit10 = req.mode == agu_pkg::MODE_LIT10;
  wire is_rdir = req.mode == agu_pkg::MODE_REG_DIRECT;

  // near space is zero extended from the 13-bit field
  wire [15:0] near_addr = {{(agu_pkg::DATA_W - agu_pkg::NEAR_W){1'b0}}, req.file_addr[agu_pkg::NEAR_W-1:0]};
  // the pre-modified pointer doubles as the write-back value, so both always agree
  wire [15:0] pre_ptr = ptr_add(req.ptr_val, req.modifier);
  wire [15:0] lit5 = {{(agu_pkg::DATA_W - agu_pkg::LIT5_W){1'b0}}, req.literal[agu_pkg::LIT5_W-1:0]};
  wire [15:0] lit10 = {{(agu_pkg::DATA_W - agu_pkg::LIT10_W){1'b0}}, req.literal[agu_pkg::LIT10_W-1:0]};

  // address selection; literal and register direct form no memory address
  wire [15:0] ea =
    is_file ? near_addr :
    is_file_full ? req.file_addr :
    is_pre ? pre_ptr :
    is_roff ? ptr_add(req.ptr_val, req.base_val) :
    is_loff ? ptr_add(req.ptr_val, req.literal) :
    (is_indirect | is_post) ? req.ptr_val :
    16'h0000;
  wire is_lit = is_lit5 | is_lit10;
  wire [15:0] operand = is_lit5 ? lit5 : is_lit10 ? lit10 : is_rdir ? req.ptr_val : 16'h0000;

  // write back only for the modifying modes; plain indirect leaves pointer alone
  wire wb_en = req.valid & (is_pre | is_post);
  wire [15:0] wb_val = pre_ptr;

  // file ops return to the file register or the implied work register
  wire dest_work = (is_file | is_file_full) & ~req.result_to_file;

  // ********************************************************************
  // software stack
  // ********************************************************************
  wire push_op = (stack_op == agu_pkg::STK_PUSH) | (stack_op == agu_pkg::STK_EXC_PUSH);
  wire pop_op = stack_op == agu_pkg::STK_POP;
  wire exc_op = stack_op == agu_pkg::STK_EXC_PUSH;
  wire [15:0] sp_dec = ptr_add(stack_ptr_val, -agu_pkg::WORD_STEP);
  wire [15:0] sp_inc = ptr_add(stack_ptr_val, agu_pkg::WORD_STEP);

  // an exception push moves the pointer and meets the limit exactly as a call push
  // pc push takes two words: low then high, sp moves by two words
  wire [15:0] stk_ea = pop_op ? sp_dec : stack_ptr_val;
  wire [15:0] sp_next = pop_op ? sp_dec : push_op ? ptr_add(sp_inc, agu_pkg::WORD_STEP) : stack_ptr_val;
  wire [15:0] pc_hi_call = {9'h000, pc_val[22:16]};
  wire [15:0] pc_hi_exc = {status_low_byte, 1'b0, pc_val[22:16]};

  // every stack-pointer based operand address and every push checks against the limit; pops do not
  wire ptr_is_sp = req.valid & ~is_lit & ~is_rdir & ~is_file & ~is_file_full & (req.ptr_idx == agu_pkg::SP_IDX);
  wire stk_act = push_op | pop_op;
  // a push at the limit itself is allowed, the one beyond it traps; the compare
  // is strict so that software can place the limit on the last usable word
  wire push_over = push_op & (stk_ea > limit_q);
  // stack-pointer operands are checked as well as pushes; pops meet only the floor
  wire ptr_over = ptr_is_sp & (ea > limit_q);
  wire limit_hit = push_over | ptr_over;
  // the floor guards the special register space below the stack
  wire stk_under = stk_act & (stk_ea < agu_pkg::STACK_FLOOR);
  wire ptr_under = ptr_is_sp & (ea < agu_pkg::STACK_FLOOR);
  wire under_hit = stk_under | ptr_under;
  // trap leaves with the address it belongs to
  wire next_stack_error = limit_hit | under_hit;

  // ********************************************************************
  // secure ram segments
  // ********************************************************************
  // windows are inclusive at both ends; a window with lo above hi protects nothing
  // refusal blocks the access itself, not only the write-back
  wire mem_access = req.valid & ~is_lit & ~is_rdir;
  wire boot_deny = boot_secure_en & in_window(ea, boot_secure_lo, boot_secure_hi) & ~exec_in_boot_flash;
  wire seg_deny = segment_secure_en & in_window(ea, segment_secure_lo, segment_secure_hi) & ~exec_in_secure_flash;
  wire refused = mem_access & (boot_deny | seg_deny);

  // ********************************************************************
  // registered outputs
  // ********************************************************************
  agu_pkg::agu_rsp_s next_rsp;

  // refused accesses are suppressed, not just flagged
  always_comb begin
    next_rsp.valid = req.valid & ~refused;
    next_rsp.eff_addr = ea;
    next_rsp.is_literal = is_lit;
    next_rsp.operand = operand;
    next_rsp.wb_en = wb_en & ~refused;
    next_rsp.wb_idx = req.ptr_idx;
    next_rsp.wb_val = wb_val;
    next_rsp.dest_is_work = dest_work;
    next_rsp.dest_idx = dest_work ? agu_pkg::DEFAULT_WORK_IDX : req.base_idx;
  end

  // ********************************************************************
  // operand answer registers
  // ********************************************************************
  // all outputs but the limit readback land one clock after the request; one register a process keeps
  // each block short and lets every output be traced straight to its flop
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rsp <= '0;
    end else begin
      rsp <= next_rsp;
    end
  end

  // operand one is always a plain register copy, never a memory fetch
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      op1_out <= 16'h0000;
    end else begin
      op1_out <= op1_val;
    end
  end

  // refusal flag stands beside the suppressed answer for the exception unit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      access_refused <= 1'b0;
    end else begin
      access_refused <= refused;
    end
  end

  // ********************************************************************
  // stack port registers
  // ********************************************************************
  // next values of the stack port, named so each register stays short
  wire next_stk_valid = stk_act;
  wire next_stk_write = push_op;
  wire [15:0] next_stk_addr = stk_ea;
  wire [15:0] next_stk_wdata_lo = pc_val[15:0];
  // call and exception frames differ only in the high word
  wire [15:0] next_stk_wdata_hi = exc_op ? pc_hi_exc : pc_hi_call;

  // strobe for the data memory; pops read, pushes write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stk_valid <= 1'b0;
    end else begin
      stk_valid <= next_stk_valid;
    end
  end

  // byte address of the stack access
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stk_addr <= 16'h0000;
    end else begin
      stk_addr <= next_stk_addr;
    end
  end

  // direction of the stack access
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stk_write <= 1'b0;
    end else begin
      stk_write <= next_stk_write;
    end
  end

  // low word of the pushed frame
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stk_wdata_lo <= 16'h0000;
    end else begin
      stk_wdata_lo <= next_stk_wdata_lo;
    end
  end

  // high word of the pushed frame
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stk_wdata_hi <= 16'h0000;
    end else begin
      stk_wdata_hi <= next_stk_wdata_hi;
    end
  end

  // pointer the register file writes back; the block never holds it itself
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      next_sp_out <= 16'h0000;
    end else begin
      next_sp_out <= sp_next;
    end
  end

  // trap leaves in the same cycle as the address it belongs to
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stack_error <= 1'b0;
    end else begin
      stack_error <= next_stack_error;
    end
  end

  // ********************************************************************
  // limit readback
  // ********************************************************************
  // limit readback, bit zero always clear; it sits one clock behind the
  // value the compare uses, so a read right after a write shows the old limit
  always_ff @(posedge clock) begin
    stack_limit_reg <= limit_q & agu_pkg::ALIGN_MASK;
  end

  // operand one index is decoded upstream; kept only to close the port
  wire unused_idx = ^op1_idx;

endmodule

// >>> agu_pkg.sv
package agu_pkg;

  // ********************************************************************
  // widths and fixed addresses
  // ********************************************************************
  localparam int unsigned DATA_W = 16;
  localparam int unsigned NEAR_W = 13;
  localparam int unsigned LIT5_W = 5;
  localparam int unsigned LIT10_W = 10;
  localparam int unsigned REG_IDX_W = 4;
  localparam logic [15:0] STACK_FLOOR = 16'h0800;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [3:0] SP_IDX = 4'hF;
  localparam logic [3:0] DEFAULT_WORK_IDX = 4'h0;
  localparam logic [15:0] ALIGN_MASK = 16'hFFFE;

  // ********************************************************************
  // addressing modes, one-hot
  // ********************************************************************
  typedef enum logic [9:0] {
    MODE_FILE_DIRECT = 10'h001,
    MODE_REG_DIRECT = 10'h002,
    MODE_INDIRECT = 10'h004,
    MODE_POST_MOD = 10'h008,
    MODE_PRE_MOD = 10'h010,
    MODE_REG_OFFSET = 10'h020,
    MODE_LIT_OFFSET = 10'h040,
    MODE_LIT5 = 10'h080,
    MODE_LIT10 = 10'h100,
    MODE_FILE_FULL = 10'h200
  } addr_mode_e;

  // stack operations, one-hot
  typedef enum logic [3:0] {
    STK_NONE = 4'h1,
    STK_PUSH = 4'h2,
    STK_POP = 4'h4,
    STK_EXC_PUSH = 4'h8
  } stack_op_e;

  // decoded request from the instruction decoder
  typedef struct packed {
    logic valid;
    addr_mode_e mode;
    logic [3:0] ptr_idx;
    logic [3:0] base_idx;
    logic [15:0] ptr_val;
    logic [15:0] base_val;
    logic [15:0] literal;
    logic [15:0] file_addr;
    logic [15:0] modifier;
    logic result_to_file;
  } agu_req_s;

  // answer to data memory and register file
  typedef struct packed {
    logic valid;
    logic [15:0] eff_addr;
    logic is_literal;
    logic [15:0] operand;
    logic wb_en;
    logic [3:0] wb_idx;
    logic [15:0] wb_val;
    logic dest_is_work;
    logic [3:0] dest_idx;
  } agu_rsp_s;

endpackage

// >>> agu_chk.sv
`timescale 1ns/1ps
// ********************************************************************
// address and stack checks
// ********************************************************************
module agu_chk (
  input wire logic clock,
  input wire logic rst,
  input wire agu_pkg::agu_req_s req,
  input wire agu_pkg::stack_op_e stack_op,
  input wire logic [15:0] stack_ptr_val,
  input wire logic [22:0] pc_val,
  input wire logic [7:0] status_low_byte,
  input wire logic limit_wr,
  input wire logic [15:0] limit_wdata,
  input wire agu_pkg::agu_rsp_s rsp,
  input wire logic stk_valid,
  input wire logic [15:0] stk_addr,
  input wire logic [15:0] stk_wdata_hi,
  input wire logic [15:0] next_sp_out,
  input wire logic stack_error,
  input wire logic access_refused,
  input wire logic [15:0] stack_limit_reg
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic lim_set;
  logic lim_wr_d;
  // the readback port settles two edges after a write, so skip the edge between
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lim_wr_d <= 1'b0;
    end else begin
      lim_wr_d <= limit_wr;
    end
  end
  // the limit has no reset value, so it is trusted only once written
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lim_set <= 1'b0;
    end else if (limit_wr) begin
      lim_set <= 1'b1;
    end
  end
  wire push = stack_op == agu_pkg::STK_PUSH;
  wire ok_lim = lim_set && !limit_wr && !lim_wr_d;
  wire post_m = req.valid && req.mode == agu_pkg::MODE_POST_MOD;
  wire pre_m = req.valid && req.mode == agu_pkg::MODE_PRE_MOD;
  a_push_post_inc: assert property (push |=> stk_valid && stk_addr == $past(stack_ptr_val)
    && next_sp_out == $past(stack_ptr_val) + 16'h0004) else $error("push address wrong");
  a_pop_pre_dec: assert property (stack_op == agu_pkg::STK_POP |=>
    stk_addr == $past(stack_ptr_val) - 16'h0002 && next_sp_out == stk_addr) else $error("pop address wrong");
  a_call_top_clear: assert property (push |=> stk_wdata_hi == {9'h000, $past(pc_val[22:16])})
    else $error("call push high word wrong");
  a_exc_status_merge: assert property (stack_op == agu_pkg::STK_EXC_PUSH |=>
    stk_wdata_hi == {$past(status_low_byte), 1'b0, $past(pc_val[22:16])}) else $error("exception word wrong");
  a_limit_aligned: assert property (limit_wr |-> ##2 stack_limit_reg == ($past(limit_wdata, 2) & 16'hFFFE))
    else $error("limit not aligned");
  a_limit_equal_ok: assert property (push && ok_lim && stack_ptr_val == stack_limit_reg
    && stack_ptr_val >= 16'h0800 |=> !stack_error) else $error("trap at limit");
  a_limit_over_trap: assert property (push && ok_lim && stack_ptr_val > stack_limit_reg |=> stack_error)
    else $error("no trap above limit");
  a_underflow_trap: assert property (push && stack_ptr_val < 16'h0800 |=> stack_error)
    else $error("no underflow trap");
  a_post_mod_addr: assert property (post_m |=> access_refused || (rsp.eff_addr == $past(req.ptr_val)
    && rsp.wb_val == $past(req.ptr_val) + $past(req.modifier))) else $error("post modify wrong");
  a_pre_mod_addr: assert property (pre_m |=> access_refused
    || rsp.eff_addr == $past(req.ptr_val) + $past(req.modifier)) else $error("pre modify wrong");
  c_trap: cover property (push ##1 stack_error);
  c_pop: cover property (stack_op == agu_pkg::STK_POP);
  c_refuse: cover property (req.valid ##1 access_refused);
endmodule
bind data_address_generation_stack_check agu_chk i_chk (.clock, .rst, .req, .stack_op, .stack_ptr_val, .pc_val,
  .status_low_byte, .limit_wr, .limit_wdata, .rsp, .stk_valid, .stk_addr, .stk_wdata_hi, .next_sp_out,
  .stack_error, .access_refused, .stack_limit_reg);

// >>> agu_far_model.sv
`timescale 1ns/1ps
// ********************************************************************
// register file side: holds the stack pointer
// ********************************************************************
module agu_far_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic sp_load,
  input wire logic [15:0] sp_load_val,
  input wire logic stk_valid,
  input wire logic [15:0] next_sp_out,
  output logic [15:0] stack_ptr_val
);
  // apart from a direct sp_load, the pointer only moves once the block answers, as a real write-back would
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stack_ptr_val <= 16'h0800;
    end else if (sp_load) begin
      stack_ptr_val <= sp_load_val;
    end else if (stk_valid) begin
      stack_ptr_val <= next_sp_out;
    end
  end
endmodule

// >>> data_address_generation_stack_check_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
// ********************************************************************
// bench
// ********************************************************************
module data_address_generation_stack_check_tb;
  logic clock = 1'b0;
  logic rst, limit_wr, exec_in_boot_flash, exec_in_secure_flash, boot_secure_en, segment_secure_en, sp_load;
  logic [15:0] op1_val, limit_wdata, sp_load_val, stack_ptr_val, win_lo, win_hi;
  logic [3:0] op1_idx;
  logic [22:0] pc_val;
  logic [7:0] status_low_byte;
  agu_pkg::agu_req_s req;
  agu_pkg::stack_op_e stack_op;
  agu_pkg::agu_rsp_s rsp;
  logic stk_valid, stk_write, stack_error, access_refused;
  logic [15:0] op1_out, stk_addr, stk_wdata_lo, stk_wdata_hi, next_sp_out, stack_limit_reg;
  int n_tests = 0;
  int n_mismatch = 0;
  // both secure windows cover the pointer used by every request until win_lo moves to 16'h1002
  data_address_generation_stack_check i_dut (.clock, .rst, .req, .op1_val, .op1_idx, .stack_op, .stack_ptr_val,
    .pc_val, .status_low_byte, .limit_wr, .limit_wdata, .boot_secure_en, .boot_secure_lo(win_lo),
    .boot_secure_hi(win_hi), .segment_secure_en, .segment_secure_lo(win_lo), .segment_secure_hi(win_hi),
    .exec_in_boot_flash, .exec_in_secure_flash, .rsp, .op1_out, .stk_valid, .stk_addr, .stk_write,
    .stk_wdata_lo, .stk_wdata_hi, .next_sp_out, .stack_error, .access_refused, .stack_limit_reg);
  agu_far_model i_far (.clock, .rst, .sp_load, .sp_load_val, .stk_valid, .next_sp_out, .stack_ptr_val);
  always #5 clock = ~clock;
  // one request, answer sampled after the edge that registers it
  task automatic send(input agu_pkg::addr_mode_e m, input logic [3:0] sec);
    @(posedge clock);
    {boot_secure_en, segment_secure_en, exec_in_boot_flash, exec_in_secure_flash} <= sec;
    op1_val <= {m, 6'h05};
    op1_idx <= sec;
    req <= '{1'b1, m, 4'h3, 4'h5, 16'h1000, 16'h0024, 16'h07FF, 16'hFFFE, 16'hFFFE, 1'b0};
    @(posedge clock);
    req.valid <= 1'b0;
    #1;
  endtask
  task automatic sp_set(input logic [15:0] v);
    @(posedge clock);
    sp_load <= 1'b1;
    sp_load_val <= v;
    @(posedge clock);
    sp_load <= 1'b0;
  endtask
  task automatic stk(input agu_pkg::stack_op_e op);
    @(posedge clock);
    stack_op <= op;
    @(posedge clock);
    stack_op <= agu_pkg::STK_NONE;
    #1;
  endtask
  task automatic t_modes();
    send(agu_pkg::MODE_POST_MOD, 4'h0);
    `CHK(rsp.eff_addr, 16'h1000)
    `CHK(rsp.wb_val, 16'h0FFE)
    `CHK(({rsp.wb_en, rsp.wb_idx}), 5'h13)
    send(agu_pkg::MODE_PRE_MOD, 4'h0);
    `CHK(rsp.eff_addr, 16'h0FFE)
    send(agu_pkg::MODE_INDIRECT, 4'h0);
    `CHK(({rsp.eff_addr, rsp.wb_en}), 17'h02000)
    send(agu_pkg::MODE_REG_OFFSET, 4'h0);
    `CHK(rsp.eff_addr, 16'h1024)
    send(agu_pkg::MODE_LIT_OFFSET, 4'h0);
    `CHK(rsp.eff_addr, 16'h17FF)
    send(agu_pkg::MODE_FILE_DIRECT, 4'h0);
    `CHK(rsp.eff_addr, 16'h1FFE)
    `CHK(({rsp.dest_is_work, rsp.dest_idx}), 5'h10)
    send(agu_pkg::MODE_FILE_FULL, 4'h0);
    `CHK(rsp.eff_addr, 16'hFFFE)
    send(agu_pkg::MODE_LIT5, 4'h0);
    `CHK(({rsp.is_literal, rsp.operand}), 17'h1001F)
    send(agu_pkg::MODE_LIT10, 4'h0);
    `CHK(({rsp.is_literal, rsp.operand}), 17'h103FF)
    `CHK(op1_out, ({agu_pkg::MODE_LIT10, 6'h05}))
    $display("test modes done");
  endtask
  task automatic t_stack();
    @(posedge clock);
    limit_wr <= 1'b1;
    limit_wdata <= 16'h1001;
    @(posedge clock);
    limit_wr <= 1'b0;
    sp_set(16'h1000);
    stk(agu_pkg::STK_PUSH);
    `CHK(stack_limit_reg, 16'h1000)
    `CHK(({stk_addr, next_sp_out, stack_error}), 33'h020002008)
    `CHK(({stk_valid, stk_write}), 2'b11)
    `CHK(({stk_wdata_hi, stk_wdata_lo}), 32'h007ABCDE)
    stk(agu_pkg::STK_PUSH);
    `CHK(stack_error, 1'b1)
    sp_set(16'h0900);
    stk(agu_pkg::STK_POP);
    `CHK(({stk_addr, next_sp_out}), 32'h08FE08FE)
    `CHK(({stk_valid, stk_write}), 2'b10)
    stk(agu_pkg::STK_EXC_PUSH);
    `CHK(stk_wdata_hi, 16'h5A7A)
    sp_set(16'h07FE);
    stk(agu_pkg::STK_PUSH);
    `CHK(stack_error, 1'b1)
    $display("test stack done");
  endtask
  task automatic t_secure();
    send(agu_pkg::MODE_INDIRECT, 4'b1000);
    `CHK(({rsp.valid, access_refused}), 2'b01)
    send(agu_pkg::MODE_INDIRECT, 4'b1010);
    `CHK(({rsp.valid, access_refused}), 2'b10)
    send(agu_pkg::MODE_INDIRECT, 4'b0110);
    `CHK(({rsp.valid, access_refused}), 2'b01)
    send(agu_pkg::MODE_INDIRECT, 4'b0101);
    `CHK(({rsp.valid, access_refused}), 2'b10)
    @(posedge clock);
    win_lo <= 16'h1002; // pointer now sits just below both windows
    send(agu_pkg::MODE_INDIRECT, 4'b1100);
    `CHK(({rsp.valid, access_refused}), 2'b10)
    $display("test secure done");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (2000) @(posedge clock);
    n_mismatch++;
    finish_test();
  end
  initial begin
    rst = 1'b1;
    req = '0;
    {op1_val, op1_idx, limit_wr, limit_wdata, sp_load, sp_load_val} = '0;
    {boot_secure_en, segment_secure_en, exec_in_boot_flash, exec_in_secure_flash} = 4'h0;
    stack_op = agu_pkg::STK_NONE;
    pc_val = 23'h7ABCDE;
    status_low_byte = 8'h5A;
    {win_lo, win_hi} = {16'h1000, 16'h10FF};
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_modes();
    t_stack();
    t_secure();
    finish_test();
  end
endmodule
